// ===== rtl/pls_top.sv
// PLL lock status and source select, four channels, AHB-Lite registers
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module pls_top
	import pls_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RESETN,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// PLL side
	input wire logic [pls_pkg::NCH-1:0] PLL_UNLOCKED,
	input wire logic [pls_pkg::NCH-1:0] EXTERNAL_CLOCK_INPUT,
	input wire logic [pls_pkg::NCH-1:0] INTERNAL_REFERENCE_SOURCE,
	// Board pins
	input wire logic [pls_pkg::NCH-1:0] SOURCE_SELECT_INPUT,
	output logic [pls_pkg::NCH-1:0] LOCK_LOSS_OUTPUT,
	output logic [pls_pkg::NCH-1:0] LOCK_LOSS_OE_N,
	output logic [pls_pkg::NCH-1:0] CLOCK_OUTPUT_PAIR_P,
	output logic [pls_pkg::NCH-1:0] CLOCK_OUTPUT_PAIR_N,
	output logic [pls_pkg::NCH-1:0] IRQ_PIN_O,
	output logic [pls_pkg::NCH-1:0] IRQ_PIN_OE_N,
	output logic IRQ
);
	import pls_pkg::*;

	logic [15:0] ctrl_ff;
	logic [7:0] fmt_ff;
	logic [3:0] mask_ff;
	logic [3:0] stat_ff;
	logic [3:0] lock_ff;
	logic [3:0] sel_w;
	logic irq_ff;
	logic [3:0] irqo_ff, irqoe_ff;
	logic ph_ff, ph_wr_ff;
	logic [7:0] ph_addr_ff;
	logic [31:0] rdata_ff;
	logic nxt_take;
	logic [3:0] nxt_stat;
	logic rd_stat;

	// Address phase capture; slave never inserts wait states
	always_comb
	begin
		nxt_take = HSEL && HREADY && HTRANS[1]; // R10
	end
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESETN)
		begin
			ph_ff <= 1'b0;
			ph_wr_ff <= 1'b0;
			ph_addr_ff <= 8'h00;
		end
		else if (HREADY)
		begin
			ph_ff <= nxt_take;
			ph_wr_ff <= HWRITE;
			ph_addr_ff <= HADDR[7:0];
		end
	end
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	// Writes in data phase
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESETN)
		begin
			ctrl_ff <= CTRL_RESET;
			fmt_ff <= FMT_RESET;
			mask_ff <= MASK_RESET;
		end
		else if (ph_ff && ph_wr_ff)
		begin
			case (ph_addr_ff)
				ADDR_CTRL: ctrl_ff <= HWDATA[15:0];
				ADDR_FMT: fmt_ff <= HWDATA[7:0]; // R8
				ADDR_IRQ_MASK: mask_ff <= HWDATA[3:0];
				default: ;
			endcase
		end
	end

	// Read data, registered at the address phase so it stands in the data phase
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESETN)
			rdata_ff <= 32'h0000_0000;
		else if (nxt_take && !HWRITE)
		begin
			case (HADDR[7:0])
				ADDR_CTRL: rdata_ff <= {16'h0000, ctrl_ff};
				ADDR_FMT: rdata_ff <= {24'h000000, fmt_ff};
				ADDR_LOCK: rdata_ff <= {28'h0000000, lock_ff}; // R4
				ADDR_SEL: rdata_ff <= {28'h0000000, sel_w};
				ADDR_IRQ_STAT: rdata_ff <= {28'h0000000, stat_ff};
				ADDR_IRQ_MASK: rdata_ff <= {28'h0000000, mask_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end
	end
	assign HRDATA = rdata_ff;

	// Lock state sampled; loss-of-lock edge sets sticky bit, set beats read clear
	assign rd_stat = nxt_take && !HWRITE && (HADDR[7:0] == ADDR_IRQ_STAT);
	always_comb
	begin
		nxt_stat = rd_stat ? 4'h0 : stat_ff;
		nxt_stat = nxt_stat | (PLL_UNLOCKED & ~lock_ff);
	end
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESETN)
		begin
			lock_ff <= 4'h0;
			stat_ff <= 4'h0;
			irq_ff <= 1'b0;
		end
		else
		begin
			lock_ff <= PLL_UNLOCKED; // R4
			stat_ff <= nxt_stat;
			irq_ff <= |(nxt_stat & mask_ff);
		end
	end
	assign IRQ = irq_ff;

	// Per channel interrupt pins: drive only when enabled, level by polarity
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESETN)
		begin
			irqo_ff <= 4'h0;
			irqoe_ff <= 4'hf;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				irqo_ff[i] <= (stat_ff[i] & mask_ff[i]) ^ ~ctrl_ff[4*i+CTRL_IRQ_POL]; // R11
				irqoe_ff[i] <= ~ctrl_ff[4*i+CTRL_IRQ_EN]; // R11
			end
		end
	end
	assign IRQ_PIN_O = irqo_ff;
	assign IRQ_PIN_OE_N = irqoe_ff;

	// Four identical independent channels
	generate
		for (genvar c = 0; c < NCH; c++)
		begin : g_ch
			pls_chan u_ch ( // R12
				.clk(CORE_CLK),
				.rst_n(RESETN),
				.lol_en(ctrl_ff[4*c+CTRL_LOL_EN]),
				.lol_pol(ctrl_ff[4*c+CTRL_LOL_POL]),
				.fmt(fmt_ff[2*c+1:2*c]),
				.unlocked(PLL_UNLOCKED[c]),
				.sel_raw(SOURCE_SELECT_INPUT[c]),
				.ref_ext(EXTERNAL_CLOCK_INPUT[c]),
				.ref_int(INTERNAL_REFERENCE_SOURCE[c]),
				.lol_o(LOCK_LOSS_OUTPUT[c]),
				.lol_oe_n(LOCK_LOSS_OE_N[c]),
				.sel(sel_w[c]),
				.out_p(CLOCK_OUTPUT_PAIR_P[c]),
				.out_n(CLOCK_OUTPUT_PAIR_N[c])
			);
		end
	endgenerate
endmodule

// ===== rtl/pls_pkg.sv
// Constants for the PLL lock status and source select block
// Operation
// R1: Enabled lock-loss pin high when unlocked
// R2: Disabled lock-loss pin is released
// R3: Polarity bit inverts lock-loss level
// R4: Lock state always readable in status
// R5: Select pin low external, high internal
// R6: Board always drives select pins defined
// R7: Board ties unused channel select high
// R8: Format bits set differential pair drive
// R9: CMOS format drives both pins in phase
// R10: Config port is serial target, shared data; the code has a parallel AHB-Lite slave instead
// R11: Interrupt pin enabled, polarity selectable
// R12: Four independent identical channels
package pls_pkg;
	localparam int NCH = 4;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FMT = 8'h04;
	localparam logic [7:0] ADDR_LOCK = 8'h08;
	localparam logic [7:0] ADDR_SEL = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	// Control register: per channel nibble
	localparam int CTRL_LOL_EN = 0;
	localparam int CTRL_LOL_POL = 1;
	localparam int CTRL_IRQ_EN = 2;
	localparam int CTRL_IRQ_POL = 3;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [7:0] FMT_RESET = 8'h00;
	localparam logic [3:0] MASK_RESET = 4'h0;
	// Output format codes, two bits per channel
	typedef enum logic [1:0] {
		PLS_FMT_PECL = 2'b00,
		PLS_FMT_LVDS = 2'b01,
		PLS_FMT_CML = 2'b10,
		PLS_FMT_CMOS = 2'b11
	} pls_fmt_t;
endpackage

// ===== rtl/pls_chan.sv
// One PLL channel: lock pin, source select and output pair
`timescale 1ns/100ps
module pls_chan
	import pls_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Settings
	input wire logic lol_en,
	input wire logic lol_pol,
	input wire logic [1:0] fmt,
	// Status in
	input wire logic unlocked,
	input wire logic sel_raw,
	input wire logic ref_ext,
	input wire logic ref_int,
	// Outputs
	output logic lol_o,
	output logic lol_oe_n,
	output logic sel,
	output logic out_p,
	output logic out_n
);
	logic s1_ff, s2_ff, s3_ff, sel_ff;
	logic nxt_ref;
	// Three stage capture; change taken once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
			sel_ff <= 1'b1;
		end
		else
		begin
			s1_ff <= sel_raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				sel_ff <= s3_ff; // R6
		end
	end
	assign sel = sel_ff;
	always_comb
	begin
		nxt_ref = sel_ff ? ref_int : ref_ext; // R5
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			lol_o <= 1'b0;
			lol_oe_n <= 1'b1;
			out_p <= 1'b0;
			out_n <= 1'b0;
		end
		else
		begin
			lol_o <= unlocked ^ lol_pol; // R1 R3
			lol_oe_n <= ~lol_en; // R2
			out_p <= nxt_ref; // R8
			if (pls_fmt_t'(fmt) == PLS_FMT_CMOS)
				out_n <= nxt_ref; // R9
			else
				out_n <= ~nxt_ref; // R8
		end
	end
endmodule

// ===== dv/pls_top_monitor.sv
// Pin-level assertions for the PLL status block
`timescale 1ns/100ps
module pls_top_monitor (
	// Clock, reset and bus
	input wire logic CORE_CLK, RESETN, HSEL, HWRITE, HREADY, HRESP, HREADYOUT, IRQ,
	input wire logic [1:0] HTRANS,
	// Channel pins
	input wire logic [3:0] PLL_UNLOCKED, SOURCE_SELECT_INPUT, EXTERNAL_CLOCK_INPUT, INTERNAL_REFERENCE_SOURCE,
	input wire logic [3:0] LOCK_LOSS_OUTPUT, LOCK_LOSS_OE_N, CLOCK_OUTPUT_PAIR_P, CLOCK_OUTPUT_PAIR_N,
	input wire logic [3:0] IRQ_PIN_O, IRQ_PIN_OE_N
);
	logic [3:0] hist_ff;
	logic quiet;
	// Settings may move for a few cycles after a write or reset
	always_ff @(posedge CORE_CLK) hist_ff <= {hist_ff[2:0], RESETN & ~(HSEL & HREADY & HTRANS[1] & HWRITE)};
	assign quiet = &hist_ff;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	resp_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus answer not okay");
	reset_idle_a: assert property (!$past(RESETN) |-> &LOCK_LOSS_OE_N && &IRQ_PIN_OE_N && !IRQ)
		else $error("pins driven after reset");
	lol_track_a: assert property (quiet |-> (LOCK_LOSS_OUTPUT ^ $past(LOCK_LOSS_OUTPUT)) ==
		($past(PLL_UNLOCKED) ^ $past(PLL_UNLOCKED, 2))) else $error("lock pin not tracking");
	sel_route_a: assert property ($stable(SOURCE_SELECT_INPUT)[*8] |-> CLOCK_OUTPUT_PAIR_P ==
		$past((SOURCE_SELECT_INPUT & INTERNAL_REFERENCE_SOURCE) | (~SOURCE_SELECT_INPUT & EXTERNAL_CLOCK_INPUT)))
		else $error("wrong reference on output");
	pair_form_a: assert property (quiet |-> $stable(CLOCK_OUTPUT_PAIR_P ^ CLOCK_OUTPUT_PAIR_N))
		else $error("pair format moved");
	lol_oe_a: assert property (quiet |-> $stable(LOCK_LOSS_OE_N)) else $error("lock enable moved");
	irq_oe_a: assert property (quiet |-> $stable(IRQ_PIN_OE_N)) else $error("irq enable moved");
	// Pin lags the level output by one cycle; IRQ is required low for three cycles
	irq_pin_a: assert property (quiet && !IRQ && !$past(IRQ) && !$past(IRQ, 2) |-> $stable(IRQ_PIN_O))
		else $error("irq pin moved while idle");
endmodule
bind pls_top pls_top_monitor i_pls_top_monitor (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .HSEL(HSEL),
	.HWRITE(HWRITE), .HREADY(HREADY), .HRESP(HRESP), .HREADYOUT(HREADYOUT), .IRQ(IRQ), .HTRANS(HTRANS),
	.PLL_UNLOCKED(PLL_UNLOCKED), .SOURCE_SELECT_INPUT(SOURCE_SELECT_INPUT),
	.EXTERNAL_CLOCK_INPUT(EXTERNAL_CLOCK_INPUT), .INTERNAL_REFERENCE_SOURCE(INTERNAL_REFERENCE_SOURCE),
	.LOCK_LOSS_OUTPUT(LOCK_LOSS_OUTPUT), .LOCK_LOSS_OE_N(LOCK_LOSS_OE_N),
	.CLOCK_OUTPUT_PAIR_P(CLOCK_OUTPUT_PAIR_P), .CLOCK_OUTPUT_PAIR_N(CLOCK_OUTPUT_PAIR_N),
	.IRQ_PIN_O(IRQ_PIN_O), .IRQ_PIN_OE_N(IRQ_PIN_OE_N));

// ===== dv/pls_board.sv
// Board model: drives source selects, watches lock pins
`timescale 1ns/100ps
module pls_board (
	// Inputs
	input wire logic clk,
	input wire logic [3:0] req, used, lol, oe_n,
	// Outputs
	output logic [3:0] sel, lol_w
);
	logic [3:0] last_ff;
	assign sel = (req & used) | ~used;
	// Released pin shows no stale level
	always_ff @(posedge clk) last_ff <= (last_ff & oe_n) | (lol & ~oe_n);
	assign lol_w = (lol & ~oe_n) | (~last_ff & oe_n);
endmodule

// ===== dv/pls_top_test.sv
// Self-checking bench for the PLL status block
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module pls_top_test;
	import pls_pkg::*;
	logic clk = 0, rst_n = 0, hw = 0, hro, hresp, irq;
	logic [1:0] ht = 0;
	logic [31:0] ha = 0, hd = 0, hr, q;
	logic [3:0] unl = 0, ext = 0, intr = 0, req = 0, used = 0, lol, oe, pp, pn, io, ioe, selw, lolw, s, pe, cm;
	logic [7:0] fm;
	int fail_count = 0, check_count = 0, seed = 76, c, f, k;
	always #20 clk = ~clk;
	pls_top i_pls_top (.CORE_CLK(clk), .RESETN(rst_n), .HSEL(1'b1), .HADDR(ha), .HTRANS(ht), .HWRITE(hw),
		.HSIZE(3'h2), .HWDATA(hd), .HREADY(hro), .HRDATA(hr), .HREADYOUT(hro), .HRESP(hresp),
		.PLL_UNLOCKED(unl), .EXTERNAL_CLOCK_INPUT(ext), .INTERNAL_REFERENCE_SOURCE(intr),
		.SOURCE_SELECT_INPUT(selw), .LOCK_LOSS_OUTPUT(lol), .LOCK_LOSS_OE_N(oe), .CLOCK_OUTPUT_PAIR_P(pp),
		.CLOCK_OUTPUT_PAIR_N(pn), .IRQ_PIN_O(io), .IRQ_PIN_OE_N(ioe), .IRQ(irq));
	pls_board i_pls_board (.clk(clk), .req(req), .used(used), .lol(lol), .oe_n(oe), .sel(selw), .lol_w(lolw));
	function automatic logic [3:0] nib(input int v, input int b);
		for (int i = 0; i < 4; i++) nib[i] = v[4*i+b];
	endfunction
	task automatic bus(input logic w, input logic [7:0] a, input int d);
		@(posedge clk);
		ht <= 2'h2;
		hw <= w;
		ha <= {24'h0, a};
		do @(posedge clk); while (!hro);
		ht <= 2'h0;
		hd <= d;
		do @(posedge clk); while (!hro);
		q = hr;
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#100000;
		fail_count++;
		close_out;
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(0, ADDR_CTRL, 0); `CHK("ctrl", CTRL_RESET, q[15:0])
		bus(0, ADDR_IRQ_MASK, 0); `CHK("mask", MASK_RESET, q[3:0])
		bus(0, 8'h18, 0); `CHK("unmapped", 32'h0, q)
		repeat (8)
		begin
			c = $random(seed) & 32'h3333;
			bus(1, ADDR_CTRL, c);
			unl <= 4'($random(seed));
			repeat (3) @(posedge clk);
			#1 `CHK("lol", unl ^ nib(c, 1), lol)
			`CHK("oe", ~nib(c, 0), oe)
			`CHK("pin", (unl ^ nib(c, 1)) & nib(c, 0), lolw & nib(c, 0))
			bus(0, ADDR_LOCK, 0); `CHK("lock", unl, q[3:0])
		end
		for (f = 0; f < 4; f++)
		begin
			fm = {2'(f + 3), 2'(f + 2), 2'(f + 1), 2'(f)};
			bus(1, ADDR_FMT, {24'h0, fm});
			req <= 4'($random(seed));
			used <= 4'($random(seed));
			ext <= 4'($random(seed));
			intr <= 4'($random(seed));
			repeat (10) @(posedge clk);
			#1 s = req | ~used;
			pe = (s & intr) | (~s & ext);
			for (k = 0; k < 4; k++) cm[k] = &fm[2*k+:2];
			`CHK("pair_p", pe, pp)
			`CHK("pair_n", pe ^ ~cm, pn)
			bus(0, ADDR_SEL, 0); `CHK("sel", s, q[3:0])
			bus(0, ADDR_FMT, 0); `CHK("fmt", fm, q[7:0])
		end
		unl <= 4'h0;
		bus(1, ADDR_CTRL, 32'h444c);
		bus(1, ADDR_IRQ_MASK, 32'h1);
		bus(0, ADDR_IRQ_STAT, 0);
		repeat (2) @(posedge clk);
		#1 `CHK("irq_idle", 4'he, io)
		@(posedge clk);
		unl <= 4'h3;
		repeat (3) @(posedge clk);
		#1 `CHK("irq_set", 1'b1, irq)
		`CHK("irq_pin", 4'hf, io)
		`CHK("irq_oe", 4'h0, ioe)
		bus(0, ADDR_IRQ_STAT, 0); `CHK("irq_stat", 4'h3, q[3:0])
		repeat (2) @(posedge clk);
		#1 `CHK("irq_clr", 1'b0, irq)
		close_out;
	end
endmodule
